//--- core/rg1_regs.svh
// register offsets, field positions and fixed defaults of the regulator 1 control bank
`ifndef RG1_REGS_SVH
`define RG1_REGS_SVH

// register offsets on the control port
`define RG1_ADDR_CONTROL   8'hc8
`define RG1_ADDR_SEQUENCE  8'hc9
`define RG1_ADDR_LOWPOWER  8'hca
`define RG1_ADDR_STATUS    8'hd0
`define RG1_ADDR_MASK      8'hd1
`define RG1_ADDR_HIBERNATE 8'hd2
`define RG1_ADDR_STATE     8'hd3

// control register fields
`define RG1_SWITCH_MODE  14
`define RG1_FLOAT_SELECT 10
`define RG1_VOLT_CODE    4:0
// sequencing register fields
`define RG1_FAULT_ACTION 15:14
`define RG1_STARTUP_SLOT 13:10
`define RG1_SHUTDN_SLOT  9:6
// low power register fields
`define RG1_HIB_BEHAV    13:12
`define RG1_HIB_SOURCE   9:8
`define RG1_IMAGE_VOLT   4:0
// state register fields
`define RG1_ST_ENABLE    15
`define RG1_ST_DISCHARGE 14
`define RG1_ST_HIBERNATE 13
`define RG1_ST_CODE      4:0

// writable bits of the control, sequencing and low power registers
`define RG1_WMASK_CONTROL  16'h441f
`define RG1_WMASK_SEQUENCE 16'hffc0
`define RG1_WMASK_LOWPOWER 16'h331f

// fixed mask-programmed defaults
`define RG1_DEF_CONTROL  16'h001c
`define RG1_DEF_SEQUENCE 16'h0000
`define RG1_DEF_LOWPOWER 16'h001c

// slot codes
`define RG1_SLOT_NEVER  4'h0
`define RG1_SLOT_ACTIVE 4'hf
`define RG1_SLOT_OFF    4'hf

// fault actions
`define RG1_FAULT_IGNORE 2'h0
`define RG1_FAULT_REG_SD 2'h1

// hibernate behaviour and sources
`define RG1_HIB_DISABLE 2'h1
`define RG1_SRC_REGBIT  2'h0
`define RG1_SRC_LP_ONE  2'h1
`define RG1_SRC_LP_TWO  2'h2

// voltage mapping, millivolts
`define RG1_CODE_HIGH   5'h10
`define RG1_MV_LOW_BASE 12'h384
`define RG1_MV_LOW_STEP 12'h032
`define RG1_MV_HI_BASE  12'h708
`define RG1_MV_HI_STEP  12'h064

// interrupt status bits
`define RG1_EV_FAULT 0
`define RG1_EV_ON    1
`define RG1_EV_OFF   2
`define RG1_EV_WIDTH 3

`endif

//--- core/rg1_pkg.sv
// types shared by the regulator 1 control bank
package rg1_pkg;

  // power state machine signals seen by the bank
  typedef struct packed {
    logic       slotStrobe;
    logic [3:0] slot;
    logic       powerUp;
    logic       enterActive;
    logic       enterOff;
    logic       resetFields;
  } rg1_psm_s;

  // regulator on/off state, one-hot
  typedef enum logic [1:0] {
    RG1_OFF = 2'b01,
    RG1_ON  = 2'b10
  } rg1_pwr_e;

  // whole state of the bank
  typedef struct packed {
    logic [15:0] regulator1Control;
    logic [15:0] regulator1Sequencing;
    logic [15:0] regulator1LowPower;
    logic        hibernateBit;
    logic [2:0]  status;
    logic [2:0]  mask;
    rg1_pwr_e    pwr;
    logic        enable;
    logic        discharge;
    logic        switchMode;
    logic [4:0]  voltCode;
    logic [11:0] millivolts;
    logic        sysShutdown;
    logic [15:0] rdata;
  } rg1_state_s;

endpackage

//--- core/rg1_slot_ctl.sv
// start-up and shutdown slot matching against the power state machine
`include "rg1_regs.svh"

module rg1_slot_ctl (
  // sequencer
  input  rg1_pkg::rg1_psm_s psm,
  // configured slots
  input  wire logic [3:0]   startupSlot,
  input  wire logic [3:0]   shutdownSlot,
  // decisions
  output logic              turnOn,
  output logic              turnOff
);
  import rg1_pkg::*;

  logic slotUp;
  logic slotDown;
  logic sdOnOff;

  // slot counter matches, only in the direction of travel
  assign slotUp   = psm.slotStrobe && psm.powerUp && (psm.slot == startupSlot);
  assign slotDown = psm.slotStrobe && !psm.powerUp && (psm.slot == shutdownSlot);
  assign sdOnOff  = (shutdownSlot == `RG1_SLOT_NEVER) || (shutdownSlot == `RG1_SLOT_OFF);

  // start-up: never, slot 1..14, or on entering active
  always_comb begin
    turnOn = 1'b0;
    if (startupSlot == `RG1_SLOT_NEVER) begin // R7
      turnOn = 1'b0;
    end else if (startupSlot == `RG1_SLOT_ACTIVE) begin
      turnOn = psm.enterActive; // R7 R13
    end else begin
      turnOn = slotUp; // R7 R13
    end
  end

  // shutdown: slot 1..14, or on entering off
  always_comb begin
    turnOff = 1'b0;
    if (sdOnOff) begin
      turnOff = psm.enterOff; // R8 R13
    end else begin
      turnOff = slotDown; // R8 R13
    end
  end

endmodule

//--- core/rg1_vcode.sv
// effective voltage code selection and code-to-millivolt mapping
`include "rg1_regs.svh"

module rg1_vcode (
  // settings
  input  wire logic       hibActive,
  input  wire logic [1:0] hibBehaviour,
  input  wire logic [4:0] normalCode,
  input  wire logic [4:0] imageCode,
  // results
  output logic [4:0]      code,
  output logic            hibDisable,
  output logic [11:0]     millivolts
);

  logic [11:0] lowSteps;
  logic [11:0] highSteps;

  // hibernate picks the image code or disables the output
  always_comb begin
    hibDisable = hibActive && (hibBehaviour == `RG1_HIB_DISABLE); // R9
    code       = normalCode; // R4
    if (hibActive && !hibDisable) begin
      code = imageCode; // R9 R11
    end
  end

  // 50 mV steps below 1.8 V, 100 mV steps from there
  always_comb begin
    lowSteps  = 12'({7'h00, code} * `RG1_MV_LOW_STEP);
    highSteps = 12'({7'h00, code - `RG1_CODE_HIGH} * `RG1_MV_HI_STEP);
    if (code < `RG1_CODE_HIGH) begin
      millivolts = `RG1_MV_LOW_BASE + lowSteps; // R4 R11
    end else begin
      millivolts = `RG1_MV_HI_BASE + highSteps; // R4 R11
    end
  end

endmodule

//--- core/rg1_control_regs.sv
// regulator 1 control and configuration bank with sequencing and fault handling
// Operation
// R1 - switch mode bit 14: 0 regulates voltage, 1 current-limited switch ignoring code
// R2 - when disabled, float select bit 10 at 0 discharges, 1 floats
// R3 - all four regulators disabled forces discharge regardless of float select
// R4 - five-bit voltage code: 0.9-1.65V in 50mV, 1.8-3.3V in 100mV
// R5 - fault action 15:14: ignore, regulator off, system off, 11 system off
// R6 - every fault raises the interrupt event, whatever the fault action
// R7 - startup slot 13:10: 0 never, 1-14 slot, 15 on entering active
// R8 - shutdown slot 9:6: 1-14 slot, 0 or 15 on entering off
// R9 - hibernate behaviour 13:12: 00 image settings, 01 disable output
// R10 - hibernate source 9:8: register bit, low power input one, two, three
// R11 - in hibernate with image selected the image code sets the voltage
// R12 - state machine reloads the fields from fixed mask defaults
// R13 - enable follows slot counter matches and active or off entry
`include "rg1_regs.svh"

module rg1_control_regs (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // register port
  input  wire logic [7:0]   regAddr,
  input  wire logic [15:0]  regWdata,
  input  wire logic         regWr,
  input  wire logic         regRd,
  output logic [15:0]       regRdata,
  // power state machine
  input  rg1_pkg::rg1_psm_s psm,
  // other regulators and fault
  input  wire logic [2:0]   otherRegOn,
  input  wire logic         regFault,
  // low power inputs
  input  wire logic         low_power_input_one,
  input  wire logic         low_power_input_two,
  input  wire logic         low_power_input_three,
  // regulator drive
  output logic              regEnable,
  output logic              regSwitchMode,
  output logic              regDischarge,
  output logic [4:0]        regVoltCode,
  output logic [11:0]       regMillivolts,
  // system
  output logic              sysShutdownReq,
  output logic              irq
);
  import rg1_pkg::*;

  rg1_state_s state;
  rg1_state_s next_state;

  logic        turnOn;
  logic        turnOff;
  logic        hibActive;
  logic        hibDisable;
  logic [4:0]  effCode;
  logic [11:0] effMv;
  logic [1:0]  faultAction;
  logic        faultRegOff;
  logic        faultSysOff;
  logic        outOn;
  logic        allOff;
  logic [2:0]  events;
  logic [15:0] stateWord;
  logic        switchSel;
  logic        floatSel;
  logic [4:0]  normalCode;
  logic [3:0]  startupSlot;
  logic [3:0]  shutdownSlot;
  logic [1:0]  hibBehaviour;
  logic [1:0]  hibSource;
  logic [4:0]  imageCode;
  logic        wrControl;
  logic        wrSequence;
  logic        wrLowPower;
  logic        wrStatus;
  logic        wrMask;
  logic        wrHibernate;
  logic [2:0]  statusClr;
  logic [2:0]  irqBit;
  logic        next_enable;
  logic        next_switchMode;
  logic        next_discharge;
  logic [4:0]  next_voltCode;
  logic [11:0] next_millivolts;
  logic [15:0] readWord;

  // field views of the configuration registers
  always_comb begin
    switchSel    = state.regulator1Control[`RG1_SWITCH_MODE];
    floatSel     = state.regulator1Control[`RG1_FLOAT_SELECT];
    normalCode   = state.regulator1Control[`RG1_VOLT_CODE];
    startupSlot  = state.regulator1Sequencing[`RG1_STARTUP_SLOT];
    shutdownSlot = state.regulator1Sequencing[`RG1_SHUTDN_SLOT];
    hibBehaviour = state.regulator1LowPower[`RG1_HIB_BEHAV];
    hibSource    = state.regulator1LowPower[`RG1_HIB_SOURCE];
    imageCode    = state.regulator1LowPower[`RG1_IMAGE_VOLT];
  end

  // write strobes per register, other addresses decode to nothing
  always_comb begin
    wrControl   = regWr && (regAddr == `RG1_ADDR_CONTROL);
    wrSequence  = regWr && (regAddr == `RG1_ADDR_SEQUENCE);
    wrLowPower  = regWr && (regAddr == `RG1_ADDR_LOWPOWER);
    wrStatus    = regWr && (regAddr == `RG1_ADDR_STATUS);
    wrMask      = regWr && (regAddr == `RG1_ADDR_MASK);
    wrHibernate = regWr && (regAddr == `RG1_ADDR_HIBERNATE);
    statusClr   = wrStatus ? regWdata[`RG1_EV_WIDTH-1:0] : 3'h0;
  end

  // slot matching against the sequencer
  rg1_slot_ctl u_slot (
    .psm          (psm),
    .startupSlot  (startupSlot),
    .shutdownSlot (shutdownSlot),
    .turnOn       (turnOn),
    .turnOff      (turnOff)
  );

  // voltage selection and mapping
  rg1_vcode u_vcode (
    .hibActive    (hibActive),
    .hibBehaviour (hibBehaviour),
    .normalCode   (normalCode),
    .imageCode    (imageCode),
    .code         (effCode),
    .hibDisable   (hibDisable),
    .millivolts   (effMv)
  );

  // hibernate trigger source select
  always_comb begin
    case (hibSource)
      `RG1_SRC_REGBIT: hibActive = state.hibernateBit; // R10
      `RG1_SRC_LP_ONE: hibActive = low_power_input_one; // R10
      `RG1_SRC_LP_TWO: hibActive = low_power_input_two; // R10
      default:         hibActive = low_power_input_three; // R10
    endcase
  end

  // fault response decode
  always_comb begin
    faultAction = state.regulator1Sequencing[`RG1_FAULT_ACTION];
    faultRegOff = regFault && (faultAction == `RG1_FAULT_REG_SD); // R5
    faultSysOff = regFault && (faultAction != `RG1_FAULT_IGNORE)
                  && (faultAction != `RG1_FAULT_REG_SD); // R5
  end

  // output drive derived from the current state
  always_comb begin
    outOn  = (state.pwr == RG1_ON) && !hibDisable; // R9 R13
    allOff = !outOn && (otherRegOn == 3'h0); // R3
  end

  // status word for readback
  always_comb begin
    stateWord                    = 16'h0000;
    stateWord[`RG1_ST_ENABLE]    = state.enable;
    stateWord[`RG1_ST_DISCHARGE] = state.discharge;
    stateWord[`RG1_ST_HIBERNATE] = hibActive;
    stateWord[`RG1_ST_CODE]      = state.voltCode;
  end

  // regulator drive, registered one cycle behind the state
  always_comb begin
    next_enable     = outOn;
    next_switchMode = switchSel; // R1
    next_discharge  = !outOn && (!floatSel || allOff); // R2 R3
    next_voltCode   = effCode; // R4 R11
    next_millivolts = effMv; // R4 R11
    if (switchSel) begin
      next_voltCode   = 5'h00; // R1
      next_millivolts = 12'h000; // R1
    end
  end

  // read multiplexer, unmapped addresses read zero
  always_comb begin
    case (regAddr)
      `RG1_ADDR_CONTROL:   readWord = state.regulator1Control;
      `RG1_ADDR_SEQUENCE:  readWord = state.regulator1Sequencing;
      `RG1_ADDR_LOWPOWER:  readWord = state.regulator1LowPower;
      `RG1_ADDR_HIBERNATE: readWord = {15'h0000, state.hibernateBit};
      `RG1_ADDR_STATUS:    readWord = {13'h0000, state.status};
      `RG1_ADDR_MASK:      readWord = {13'h0000, state.mask};
      `RG1_ADDR_STATE:     readWord = stateWord;
      default:             readWord = 16'h0000;
    endcase
  end

  // next state
  always_comb begin
    next_state = state;
    events     = 3'h0;

    // register writes, reserved bits kept at zero
    if (wrControl) begin
      next_state.regulator1Control = regWdata & `RG1_WMASK_CONTROL;
    end
    if (wrSequence) begin
      next_state.regulator1Sequencing = regWdata & `RG1_WMASK_SEQUENCE;
    end
    if (wrLowPower) begin
      next_state.regulator1LowPower = regWdata & `RG1_WMASK_LOWPOWER;
    end
    if (wrHibernate) begin
      next_state.hibernateBit = regWdata[0];
    end
    if (wrMask) begin
      next_state.mask = regWdata[`RG1_EV_WIDTH-1:0];
    end
    next_state.status = state.status & ~statusClr;

    // sequencer reload of the fixed defaults wins over software
    if (psm.resetFields) begin
      next_state.regulator1Control    = `RG1_DEF_CONTROL; // R12
      next_state.regulator1Sequencing = `RG1_DEF_SEQUENCE; // R12
      next_state.regulator1LowPower   = `RG1_DEF_LOWPOWER; // R12
    end

    // enable sequencing, a regulator fault shutdown wins
    if (faultRegOff && state.pwr == RG1_ON) begin
      next_state.pwr = RG1_OFF; // R5
      events[`RG1_EV_OFF] = 1'b1;
    end else begin
      case (state.pwr)
        RG1_OFF: begin
          if (turnOn && !faultRegOff) begin
            next_state.pwr = RG1_ON; // R13
            events[`RG1_EV_ON] = 1'b1;
          end
        end
        RG1_ON: begin
          if (turnOff) begin
            next_state.pwr = RG1_OFF; // R13
            events[`RG1_EV_OFF] = 1'b1;
          end
        end
        default: begin
          next_state.pwr = RG1_OFF;
        end
      endcase
    end

    // every fault is an interrupt event
    events[`RG1_EV_FAULT] = regFault; // R6

    // sticky status, a new event wins over the clear
    next_state.status = next_state.status | events;

    // system shutdown request, registered one cycle after the fault and held while the fault lasts
    next_state.sysShutdown = faultSysOff; // R5

    // registered regulator drive
    next_state.enable     = next_enable;
    next_state.switchMode = next_switchMode;
    next_state.discharge  = next_discharge;
    next_state.voltCode   = next_voltCode;
    next_state.millivolts = next_millivolts;

    // read data, one cycle after the strobe, zero when unmapped
    next_state.rdata = 16'h0000;
    if (regRd) begin
      next_state.rdata = readWord;
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state.regulator1Control    <= `RG1_DEF_CONTROL; // R12
      state.regulator1Sequencing <= `RG1_DEF_SEQUENCE; // R12
      state.regulator1LowPower   <= `RG1_DEF_LOWPOWER; // R12
      state.hibernateBit         <= 1'b0;
      state.status               <= 3'h0;
      state.mask                 <= 3'h0;
      state.pwr                  <= RG1_OFF;
      state.enable               <= 1'b0;
      state.discharge            <= 1'b1;
      state.switchMode           <= 1'b0;
      state.voltCode             <= 5'h00;
      state.millivolts           <= 12'h000;
      state.sysShutdown          <= 1'b0;
      state.rdata                <= 16'h0000;
    end else begin
      state <= next_state;
    end
  end

  // interrupt contribution of each event bit
  for (genvar g = 0; g < `RG1_EV_WIDTH; g++) begin : g_irq
    assign irqBit[g] = state.status[g] && state.mask[g]; // R6
  end

  // outputs
  assign regRdata       = state.rdata;
  assign regEnable      = state.enable;
  assign regSwitchMode  = state.switchMode;
  assign regDischarge   = state.discharge;
  assign regVoltCode    = state.voltCode;
  assign regMillivolts  = state.millivolts;
  assign sysShutdownReq = state.sysShutdown;
  assign irq            = |irqBit; // R6

endmodule

//--- verification/rg1_control_regs_asserts.sv
// concurrent checks on the regulator 1 bank ports
module rg1_control_regs_asserts (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  // sequencer and fault
  input  rg1_pkg::rg1_psm_s psm,
  input  wire logic [2:0]  otherRegOn,
  input  wire logic        regFault,
  // regulator drive
  input  wire logic        regEnable,
  input  wire logic        regSwitchMode,
  input  wire logic        regDischarge,
  input  wire logic [4:0]  regVoltCode,
  input  wire logic [11:0] regMillivolts,
  input  wire logic        sysShutdownReq
);
  import rg1_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [1:0] act;
  logic       live;
  // shadow of the fault action field, reloads win over writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      act  <= 2'h0;
      live <= 1'h0;
    end else begin
      live <= 1'h1;
      if (psm.resetFields) act <= 2'h0;
      else if (regWr && regAddr == 8'hc9) act <= regWdata[15:14];
    end
  end
  a_switch_zero: assert property (
    regSwitchMode |-> regVoltCode == 5'h00 && regMillivolts == 12'h000)
    else $error("switch mode shows a voltage");
  a_sw_follows: assert property (
    regWr && regAddr == 8'hc8 && !psm.resetFields
    |-> ##2 regSwitchMode == $past(regWdata[14], 2)) else $error("switch mode lost");
  a_mv_low_map: assert property (
    live && !regSwitchMode && !regVoltCode[4]
    |-> regMillivolts == 12'h384 + 12'h032 * {8'h00, regVoltCode[3:0]}) else $error("low mv");
  a_mv_high_map: assert property (
    live && !regSwitchMode && regVoltCode[4]
    |-> regMillivolts == 12'h708 + 12'h064 * {8'h00, regVoltCode[3:0]}) else $error("high mv");
  a_fault_sys: assert property (
    regFault && act[1] |=> sysShutdownReq) else $error("no system shutdown");
  a_no_sysdown: assert property (
    !(regFault && act[1]) |=> !sysShutdownReq) else $error("stray system shutdown");
  a_fault_off: assert property (
    regFault && act == 2'h1 |-> ##2 !regEnable) else $error("fault left output on");
  a_disch_excl: assert property (
    regDischarge |-> !regEnable) else $error("discharge while enabled");
  a_all_off_disch: assert property (
    live && !regEnable && $past(otherRegOn) == 3'h0 |-> regDischarge)
    else $error("all regulators off without discharge");
endmodule

bind rg1_control_regs rg1_control_regs_asserts chk_u (
  .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .psm(psm), .otherRegOn(otherRegOn), .regFault(regFault), .regEnable(regEnable),
  .regSwitchMode(regSwitchMode),
  .regDischarge(regDischarge), .regVoltCode(regVoltCode), .regMillivolts(regMillivolts),
  .sysShutdownReq(sysShutdownReq));

//--- verification/rg1_host_model.sv
// host model driving the register port
module rg1_host_model (
  // clock
  input  wire logic   clk,
  // register port
  output logic [7:0]  regAddr,
  output logic [15:0] regWdata,
  output logic        regWr,
  output logic        regRd
);
  timeunit 1ns;
  timeprecision 100ps;
  // quiet bus at time zero
  initial begin
    regAddr = 8'h00;
    regWdata = 16'h0000;
    regWr = 1'h0;
    regRd = 1'h0;
  end
  // write strobe held to the next edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    regRd <= 1'h0;
  endtask
  // read strobe held to the next edge
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regWr <= 1'h0;
    regRd <= 1'h1;
  endtask
  // release: strobes low, stale bus inverted
  task automatic idle();
    @(posedge clk);
    regAddr <= ~regAddr;
    regWdata <= ~regWdata;
    regWr <= 1'h0;
    regRd <= 1'h0;
  endtask
endmodule

//--- verification/rg1_control_regs_tb_top.sv
// self-checking bench for the regulator 1 bank
module rg1_control_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import rg1_pkg::*;
  // stimulus and observed signals
  logic        clk = 1'h0;
  logic        arst_n = 1'h0;
  logic        regFault = 1'h0;
  logic        lastRd = 1'h0;
  logic [2:0]  otherOn = 3'h1;
  logic [2:0]  lpIn = 3'h0;
  rg1_psm_s    psm = '0;
  logic [7:0]  regAddr;
  logic [15:0] regWdata, regRdata, d;
  logic        regWr, regRd, regEnable, regSwitchMode, regDischarge, sysShutdownReq, irq;
  logic [4:0]  regVoltCode;
  logic [11:0] regMillivolts;
  logic [15:0] expQ[$];
  int          failCount = 0;
  int          comparisons = 0;
  int          seed = 48717;
  rg1_host_model host_u (.clk(clk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd));
  rg1_control_regs dut_u (
    .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .psm(psm), .otherRegOn(otherOn), .regFault(regFault),
    .low_power_input_one(lpIn[0]), .low_power_input_two(lpIn[1]),
    .low_power_input_three(lpIn[2]), .regEnable(regEnable), .regSwitchMode(regSwitchMode),
    .regDischarge(regDischarge), .regVoltCode(regVoltCode), .regMillivolts(regMillivolts),
    .sysShutdownReq(sysShutdownReq), .irq(irq));
  // clock
  initial forever #12.5 clk = ~clk;
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // read with its expected word noted
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    expQ.push_back(e);
    host_u.rd(a);
  endtask
  task automatic settle();
    host_u.idle();
    repeat (3) @(negedge clk);
  endtask
  // one-cycle sequencer event
  task automatic ev(input logic [8:0] v);
    host_u.idle();
    psm <= v;
    @(posedge clk);
    psm <= '0;
    settle();
  endtask
  // enable, discharge and interrupt together
  task automatic outs(input logic [2:0] e);
    check("outs", 16'({regEnable, regDischarge, irq}), 16'(e));
  endtask
  // read data one cycle behind the strobe
  always @(negedge clk) begin
    if (lastRd) check("rdata", regRdata, expQ.pop_front());
    lastRd = regRd;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    finalReport();
  end
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'h1;
    // defaults, state and an unmapped read
    rdc(8'hc8, 16'h001c);
    rdc(8'hc9, 16'h0000);
    rdc(8'hca, 16'h001c);
    rdc(8'hd3, 16'h401c);
    rdc(8'h55, 16'h0000);
    // writable bits, then reload of defaults
    d = 16'($random(seed));
    host_u.wr(8'hc8, d);
    host_u.wr(8'hc9, d);
    host_u.wr(8'hca, d);
    rdc(8'hc8, d & 16'h441f);
    rdc(8'hc9, d & 16'hffc0);
    rdc(8'hca, d & 16'h331f);
    ev(9'h001);
    rdc(8'hc8, 16'h001c);
    rdc(8'hc9, 16'h0000);
    rdc(8'hca, 16'h001c);
    // every voltage code
    for (int i = 0; i < 32; i++) begin
      d = 16'($random(seed)) & 16'h041f;
      d[4:0] = 5'(i);
      host_u.wr(8'hc8, d);
      settle();
      check("code", 16'(regVoltCode), 16'(i));
      check("mv", 16'(regMillivolts), i < 16 ? 16'(900 + 50 * i) : 16'(200 + 100 * i));
    end
    host_u.wr(8'hc8, 16'h4010);
    settle();
    check("switch code", 16'(regVoltCode), 16'h0000);
    check("switch mv", 16'(regMillivolts), 16'h0000);
    check("switch", 16'(regSwitchMode), 16'h0001);
    // slot sequencing: start in slot 3, stop in slot 5
    host_u.wr(8'hd1, 16'h0007);
    host_u.wr(8'hc8, 16'h0400);
    host_u.wr(8'hc9, 16'h0d40);
    ev({1'h1, 4'h2, 4'h8});
    outs(3'h0);
    ev({1'h1, 4'h3, 4'h8});
    outs(3'h5);
    rdc(8'hd3, 16'h8000);
    rdc(8'hd0, 16'h0002);
    host_u.wr(8'hd0, 16'h0002);
    settle();
    outs(3'h4);
    ev({1'h1, 4'h5, 4'h0});
    outs(3'h1);
    host_u.idle();
    otherOn <= 3'h0;
    settle();
    outs(3'h3);
    host_u.wr(8'hc8, 16'h0000);
    host_u.idle();
    otherOn <= 3'h4;
    settle();
    outs(3'h3);
    // start on active entry, stop on off entry
    for (int k = 0; k < 2; k++) begin
      host_u.wr(8'hc9, {6'h00, k ? 4'hf : 4'h0, 6'h00});
      ev(9'h004);
      check("en", 16'(regEnable), 16'h0000);
      host_u.wr(8'hc9, {2'h0, 4'hf, k ? 4'hf : 4'h0, 6'h00});
      ev(9'h004);
      check("en", 16'(regEnable), 16'h0001);
      ev(9'h002);
      check("en", 16'(regEnable), 16'h0000);
    end
    // each fault action
    for (int a = 0; a < 4; a++) begin
      host_u.wr(8'hc9, {2'(a), 4'hf, 4'h0, 6'h00});
      ev(9'h004);
      host_u.wr(8'hd0, 16'h0007);
      host_u.idle();
      regFault <= 1'h1;
      @(posedge clk);
      regFault <= 1'h0;
      @(negedge clk);
      check("sysdown", 16'(sysShutdownReq), 16'(a >= 2));
      settle();
      check("en", 16'(regEnable), 16'(a != 1));
      rdc(8'hd0, a == 1 ? 16'h0005 : 16'h0001);
    end
    host_u.wr(8'hd1, 16'h0000);
    settle();
    check("irq", 16'(irq), 16'h0000);
    // hibernate sources and image code
    host_u.wr(8'hc8, 16'h001c);
    for (int s = 0; s < 4; s++) begin
      host_u.wr(8'hca, {6'h00, 2'(s), 8'h05});
      host_u.idle();
      lpIn <= ~3'((1 << s) >> 1);
      settle();
      check("code", 16'(regVoltCode), 16'h001c);
      if (s == 0) host_u.wr(8'hd2, 16'h0001);
      host_u.idle();
      lpIn <= 3'((1 << s) >> 1);
      settle();
      check("image", 16'(regVoltCode), 16'h0005);
      host_u.wr(8'hd2, 16'h0000);
    end
    host_u.wr(8'hca, 16'h1005);
    host_u.wr(8'hd2, 16'h0001);
    settle();
    check("hib en", 16'(regEnable), 16'h0000);
    host_u.wr(8'hd2, 16'h0000);
    settle();
    check("hib en", 16'(regEnable), 16'h0001);
    finalReport();
  end
endmodule
